/* cll_top.sv */
`timescale 1ns/1ps
// Function
// - digital local loop returns encoded transmit data
// - host mode: both loop bits set selects it
// - hardware mode: both loop pins high selects it
// - remote loop sends received data back out
// - host mode: remote bit only selects remote
// - hardware mode: remote pin only selects remote
// - local select only gives analog local loop
// - shutoff tri-states both transmit line outputs
// - global shutoff pin disables every channel
// - host shutoff bit disables its own channel
// - driver active only when pin low and, in host mode, bit low
// - no monitor transitions for 128 periods raises fault
// - send-all-ones replaces terminal data with ones
// - hardware pin starts and stops all-ones
// - host bit starts and stops all-ones
module cll_top #(
   parameter int NCH = cll_pkg::CLL_NCH,
   parameter int DM_PERIODS = cll_pkg::CLL_DM_PERIODS
) (
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // mode and global pins
   input wire logic host_mode_i,
   input wire logic transmitter_shutoff_i,
   input wire logic [NCH-1:0] local_loop_select_i,
   input wire logic [NCH-1:0] remote_loop_select_i,
   input wire logic [NCH-1:0] send_all_ones_i,
   // register port
   input wire logic [cll_pkg::CLL_AW-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [cll_pkg::CLL_DW-1:0] reg_wdata_i,
   output logic [cll_pkg::CLL_DW-1:0] reg_rdata_o,
   // terminal side
   input wire logic [NCH-1:0] tx_pos_data_i,
   input wire logic [NCH-1:0] tx_neg_data_i,
   input wire logic [NCH-1:0] tx_terminal_clock_i,
   output logic [NCH-1:0] rx_pos_data_o,
   output logic [NCH-1:0] rx_neg_data_o,
   output logic [NCH-1:0] rx_recovered_clock_o,
   // line side
   input wire logic [NCH-1:0] rx_line_pos_i,
   input wire logic [NCH-1:0] rx_line_neg_i,
   input wire logic [NCH-1:0] rx_line_clock_i,
   output logic [NCH-1:0] tx_line_pos_o,
   output logic [NCH-1:0] tx_line_neg_o,
   output logic [NCH-1:0] tx_line_oe_o,
   input wire logic [NCH-1:0] monitor_pos_input_i,
   input wire logic [NCH-1:0] monitor_neg_input_i,
   output logic [NCH-1:0] drive_fault_flag_o
);
   import cll_pkg::*;

   localparam int SW = 2 + 11 * NCH;
   localparam logic [CLL_DM_CW-1:0] DM_LIMIT = CLL_DM_CW'(DM_PERIODS);

   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic [NCH-1:0] tx_terminal_clock_d_reg;
   logic [NCH-1:0] mon_p_d_reg;
   logic [NCH-1:0] mon_n_d_reg;
   logic [CLL_DW-1:0] txctl_reg [NCH];
   logic [CLL_DW-1:0] loop_reg [NCH];
   logic [CLL_DW-1:0] rdata_next;

   // every mode, terminal and line pin crosses two flops (the register port does not); only the second stage is read
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else if (ce_i) begin
         sync1_reg <= {host_mode_i, transmitter_shutoff_i,
                       local_loop_select_i, remote_loop_select_i, send_all_ones_i,
                       tx_pos_data_i, tx_neg_data_i, tx_terminal_clock_i,
                       rx_line_pos_i, rx_line_neg_i, rx_line_clock_i,
                       monitor_pos_input_i, monitor_neg_input_i};
         sync2_reg <= sync1_reg;
      end
   end

   wire host_s = sync2_reg[SW-1];
   wire shutoff_pin_s = sync2_reg[SW-2];
   wire [NCH-1:0] llb_pin_s = sync2_reg[11*NCH-1 -: NCH];
   wire [NCH-1:0] rlb_pin_s = sync2_reg[10*NCH-1 -: NCH];
   wire [NCH-1:0] ones_pin_s = sync2_reg[9*NCH-1 -: NCH];
   wire [NCH-1:0] txp_s = sync2_reg[8*NCH-1 -: NCH];
   wire [NCH-1:0] txn_s = sync2_reg[7*NCH-1 -: NCH];
   wire [NCH-1:0] tx_terminal_clock_s = sync2_reg[6*NCH-1 -: NCH];
   wire [NCH-1:0] rxp_s = sync2_reg[5*NCH-1 -: NCH];
   wire [NCH-1:0] rxn_s = sync2_reg[4*NCH-1 -: NCH];
   wire [NCH-1:0] rx_recovered_clock_s = sync2_reg[3*NCH-1 -: NCH];
   wire [NCH-1:0] monp_s = sync2_reg[2*NCH-1 -: NCH];
   wire [NCH-1:0] monn_s = sync2_reg[NCH-1 -: NCH];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_terminal_clock_d_reg <= '0;
         mon_p_d_reg <= '0;
         mon_n_d_reg <= '0;
      end else if (ce_i) begin
         tx_terminal_clock_d_reg <= tx_terminal_clock_s;
         mon_p_d_reg <= monp_s;
         mon_n_d_reg <= monn_s;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         localparam logic [CLL_AW-1:0] BASE = CLL_AW'(ch * CLL_CH_STRIDE);
         logic [CLL_DM_CW-1:0] idle_cnt_reg;
         logic fault_reg;
         logic ones_phase_reg;
         logic enc_p_reg;
         logic enc_n_reg;
         logic line_p_reg;
         logic line_n_reg;
         logic oe_reg;
         logic rx_p_reg;
         logic rx_n_reg;
         logic rx_c_reg;
         logic local_loop_select;
         logic remote_loop_select;
         logic ones_on;
         logic tx_en;
         cll_loop_t mode;
         wire tx_terminal_clock_rise = tx_terminal_clock_s[ch] & ~tx_terminal_clock_d_reg[ch];
         wire mon_edge = (monp_s[ch] ^ mon_p_d_reg[ch]) | (monn_s[ch] ^ mon_n_d_reg[ch]);

         // host registers, all fields clear at reset
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               txctl_reg[ch] <= CLL_RESET_VAL;
               loop_reg[ch] <= CLL_RESET_VAL;
            end else if (ce_i && reg_wr_i) begin
               if (reg_addr_i == BASE + CLL_AW'(CLL_OFS_TXCTL)) begin
                  txctl_reg[ch] <= reg_wdata_i & CLL_TXCTL_MASK;
               end
               if (reg_addr_i == BASE + CLL_AW'(CLL_OFS_LOOP)) begin
                  loop_reg[ch] <= reg_wdata_i & CLL_LOOP_MASK;
               end
            end
         end

         always_comb begin
            local_loop_select = host_s ? loop_reg[ch][CLL_LOCAL_LOOP_BIT] : llb_pin_s[ch];
            remote_loop_select = host_s ? loop_reg[ch][CLL_REMOTE_LOOP_BIT] : rlb_pin_s[ch];
            ones_on = host_s ? txctl_reg[ch][CLL_SEND_ONES_BIT] : ones_pin_s[ch];
            // in hardware mode the bit is not consulted, so only the pin matters
            tx_en = ~shutoff_pin_s
                    & ~(host_s & txctl_reg[ch][CLL_TX_SHUTOFF_BIT]);
            unique case ({local_loop_select, remote_loop_select})
               2'b11: mode = CLL_DIGITAL_LOCAL;
               2'b01: mode = CLL_REMOTE;
               2'b10: mode = CLL_ANALOG_LOCAL;
               2'b00: mode = CLL_NORMAL;
            endcase
         end

         // transmit path, stepped on each terminal clock rising edge
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               ones_phase_reg <= 1'b0;
               enc_p_reg <= 1'b0;
               enc_n_reg <= 1'b0;
            end else if (ce_i && tx_terminal_clock_rise) begin
               if (mode == CLL_REMOTE) begin
                  enc_p_reg <= rxp_s[ch];
                  enc_n_reg <= rxn_s[ch];
               end else if (ones_on) begin
                  // alternate mark polarity keeps the ones pattern balanced
                  ones_phase_reg <= ~ones_phase_reg;
                  enc_p_reg <= ~ones_phase_reg;
                  enc_n_reg <= ones_phase_reg;
               end else begin
                  enc_p_reg <= txp_s[ch];
                  enc_n_reg <= txn_s[ch];
               end
            end
         end

         // line driver: data forced low while tri-stated
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               line_p_reg <= 1'b0;
               line_n_reg <= 1'b0;
               oe_reg <= 1'b0;
            end else if (ce_i) begin
               oe_reg <= tx_en;
               line_p_reg <= enc_p_reg & tx_en;
               line_n_reg <= enc_n_reg & tx_en;
            end
         end

         // receive outputs pick their source by loop mode
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               rx_p_reg <= 1'b0;
               rx_n_reg <= 1'b0;
               rx_c_reg <= 1'b0;
            end else if (ce_i) begin
               unique case (mode)
                  CLL_DIGITAL_LOCAL: begin
                     rx_p_reg <= enc_p_reg;
                     rx_n_reg <= enc_n_reg;
                     rx_c_reg <= tx_terminal_clock_d_reg[ch];
                  end
                  CLL_ANALOG_LOCAL: begin
                     // sees only what is on the line, so nothing while tri-stated
                     rx_p_reg <= line_p_reg;
                     rx_n_reg <= line_n_reg;
                     rx_c_reg <= tx_terminal_clock_d_reg[ch];
                  end
                  CLL_REMOTE, CLL_NORMAL: begin
                     rx_p_reg <= rxp_s[ch];
                     rx_n_reg <= rxn_s[ch];
                     rx_c_reg <= rx_recovered_clock_s[ch];
                  end
               endcase
            end
         end

         // drive monitor counts terminal clock periods without a transition
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               idle_cnt_reg <= '0;
               fault_reg <= 1'b0;
            end else if (ce_i) begin
               if (mon_edge) begin
                  idle_cnt_reg <= '0;
                  fault_reg <= 1'b0;
               end else if (tx_terminal_clock_rise && idle_cnt_reg != DM_LIMIT) begin
                  idle_cnt_reg <= idle_cnt_reg + 1'b1;
               end else if (idle_cnt_reg == DM_LIMIT) begin
                  fault_reg <= 1'b1;
               end
            end
         end

         assign tx_line_pos_o[ch] = line_p_reg;
         assign tx_line_neg_o[ch] = line_n_reg;
         assign tx_line_oe_o[ch] = oe_reg;
         assign rx_pos_data_o[ch] = rx_p_reg;
         assign rx_neg_data_o[ch] = rx_n_reg;
         assign rx_recovered_clock_o[ch] = rx_c_reg;
         assign drive_fault_flag_o[ch] = fault_reg;
      end
   endgenerate

   // registered read; unmapped and reserved read as zero
   always_comb begin
      rdata_next = '0;
      for (int i = 0; i < NCH; i++) begin
         if (reg_addr_i == CLL_AW'(i * CLL_CH_STRIDE) + CLL_AW'(CLL_OFS_STATUS)) begin
            rdata_next[CLL_FAULT_BIT] = drive_fault_flag_o[i];
         end
         if (reg_addr_i == CLL_AW'(i * CLL_CH_STRIDE) + CLL_AW'(CLL_OFS_TXCTL)) begin
            rdata_next = txctl_reg[i];
         end
         if (reg_addr_i == CLL_AW'(i * CLL_CH_STRIDE) + CLL_AW'(CLL_OFS_LOOP)) begin
            rdata_next = loop_reg[i];
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= '0;
      end else if (ce_i) begin
         reg_rdata_o <= rdata_next;
      end
   end
endmodule

/* cll_pkg.sv */
package cll_pkg;
   localparam int CLL_NCH = 4;
   localparam int CLL_AW = 5;
   localparam int CLL_DW = 5;
   // per-channel register window
   localparam logic [CLL_AW-1:0] CLL_CH_STRIDE = 5'h08;
   localparam logic [2:0] CLL_OFS_STATUS = 3'h0;
   localparam logic [2:0] CLL_OFS_TXCTL = 3'h1;
   localparam logic [2:0] CLL_OFS_LOOP = 3'h4;
   // transmit_control fields
   localparam int CLL_TX_SHUTOFF_BIT = 4;
   localparam int CLL_SEND_ONES_BIT = 3;
   localparam int CLL_TX_CLK_INV_BIT = 2;
   localparam int CLL_TX_LEVEL_BIT = 1;
   localparam logic [CLL_DW-1:0] CLL_TXCTL_MASK = 5'h1E;
   // loop_and_rate_control fields
   localparam int CLL_RATE_SONET_BIT = 3;
   localparam int CLL_RATE_EURO_BIT = 2;
   localparam int CLL_LOCAL_LOOP_BIT = 1;
   localparam int CLL_REMOTE_LOOP_BIT = 0;
   localparam logic [CLL_DW-1:0] CLL_LOOP_MASK = 5'h0F;
   // status field
   localparam int CLL_FAULT_BIT = 0;
   localparam logic [CLL_DW-1:0] CLL_RESET_VAL = 5'h00;
   // drive monitor: nominal 128 tx clock periods, tolerance 32
   localparam int CLL_DM_PERIODS = 128;
   localparam int CLL_DM_TOL = 32;
   localparam int CLL_DM_CW = 8;

   typedef enum logic [1:0] {
      CLL_NORMAL,
      CLL_ANALOG_LOCAL,
      CLL_DIGITAL_LOCAL,
      CLL_REMOTE
   } cll_loop_t;
endpackage

/* cll_checker.sv */
`timescale 1ns/1ps
module cll_checker #(
   parameter int NCH = 4,
   parameter int DM_PERIODS = 8
) (
   // clock, reset and pins
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic host_mode_i,
   input wire logic transmitter_shutoff_i,
   input wire logic [NCH-1:0] local_loop_select_i,
   input wire logic [NCH-1:0] remote_loop_select_i,
   input wire logic [NCH-1:0] send_all_ones_i,
   input wire logic [NCH-1:0] tx_terminal_clock_i,
   input wire logic [NCH-1:0] rx_line_pos_i,
   input wire logic [NCH-1:0] monitor_pos_input_i,
   input wire logic [NCH-1:0] monitor_neg_input_i,
   // watched outputs
   input wire logic [NCH-1:0] rx_pos_data_o,
   input wire logic [NCH-1:0] rx_recovered_clock_o,
   input wire logic [NCH-1:0] tx_line_pos_o,
   input wire logic [NCH-1:0] tx_line_neg_o,
   input wire logic [NCH-1:0] tx_line_oe_o,
   input wire logic [NCH-1:0] drive_fault_flag_o
);
   logic [4:0] cfg_q, sbl;
   logic [1:0] mon_q;
   logic tck_q;
   logic [7:0] fcnt;
   wire [4:0] cfg = {host_mode_i, transmitter_shutoff_i, local_loop_select_i[0],
      remote_loop_select_i[0], send_all_ones_i[0]};
   // pins are synchronised, so only a long-settled setup is judged
   wire hw = !host_mode_i && sbl == 5'h1F && !transmitter_shutoff_i;
   wire [1:0] lr = cfg[2:1];
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= 5'h00;
         sbl <= 5'h00;
      end else begin
         cfg_q <= cfg;
         if (cfg != cfg_q) sbl <= 5'h00;
         else if (sbl != 5'h1F) sbl <= sbl + 5'h01;
      end
   end
   // transmit clock rises since the last transition on either monitor pin
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mon_q <= 2'h0;
         tck_q <= 1'b0;
         fcnt <= 8'h00;
      end else begin
         mon_q <= {monitor_pos_input_i[0], monitor_neg_input_i[0]};
         tck_q <= tx_terminal_clock_i[0];
         if (mon_q != {monitor_pos_input_i[0], monitor_neg_input_i[0]}) fcnt <= 8'h00;
         else if (tx_terminal_clock_i[0] && !tck_q && fcnt != 8'hFF) fcnt <= fcnt + 8'h01;
      end
   end
   sequence s_off_held;
      transmitter_shutoff_i [*4];
   endsequence
   sequence s_hw_on;
      (!host_mode_i && !transmitter_shutoff_i) [*5];
   endsequence
   a_off_quiet_rails: assert property (!(|((tx_line_pos_o | tx_line_neg_o) & ~tx_line_oe_o)))
      else $error("rails driven while output disabled");
   a_global_off_all: assert property (s_off_held |-> !(|tx_line_oe_o))
      else $error("driver enabled under global shutoff");
   a_pin_release_on: assert property (s_hw_on |-> &tx_line_oe_o)
      else $error("driver off with shutoff pin low");
   a_normal_rx_path: assert property ($rose(rx_line_pos_i[0]) && hw && lr == 2'b00 |->
      ##[2:5] rx_pos_data_o[0])
      else $error("receive rail not passed in normal mode");
   a_remote_return: assert property ($rose(rx_line_pos_i[0]) && hw && lr == 2'b01 |->
      ##[2:14] tx_line_pos_o[0])
      else $error("received rail not sent back out");
   a_digital_clk_loop: assert property ($rose(tx_terminal_clock_i[0]) && hw && lr == 2'b11 |->
      ##[2:6] rx_recovered_clock_o[0])
      else $error("transmit clock not looped to receive");
   a_all_ones_marks: assert property (hw && !cfg[1] && cfg[0] |->
      tx_line_pos_o[0] || tx_line_neg_o[0])
      else $error("space sent while all ones active");
   a_fault_held_low: assert property (fcnt inside {[2:DM_PERIODS-2]} |->
      !drive_fault_flag_o[0])
      else $error("fault flag high despite transitions");
   a_fault_raised: assert property (fcnt >= DM_PERIODS + 2 |-> drive_fault_flag_o[0])
      else $error("fault flag low after silent line");
endmodule
bind cll_top cll_checker #(.NCH(NCH), .DM_PERIODS(DM_PERIODS)) cll_checker_inst (
   .ref_clk_i, .rst_i, .host_mode_i, .transmitter_shutoff_i, .local_loop_select_i,
   .remote_loop_select_i, .send_all_ones_i, .tx_terminal_clock_i, .rx_line_pos_i,
   .monitor_pos_input_i, .monitor_neg_input_i, .rx_pos_data_o, .rx_recovered_clock_o,
   .tx_line_pos_o, .tx_line_neg_o, .tx_line_oe_o, .drive_fault_flag_o);

/* cll_framer_model.sv */
`timescale 1ns/1ps
module cll_framer_model #(
   parameter int NCH = 4
) (
   // terminal transmit side
   output logic [NCH-1:0] tx_pos_data_o,
   output logic [NCH-1:0] tx_neg_data_o,
   output logic [NCH-1:0] tx_terminal_clock_o
);
   logic [1:0] seq = 2'h0;
   // free-running, phase unrelated to the reference clock
   initial begin
      tx_terminal_clock_o = {NCH{1'b0}};
      #37;
      forever #200 tx_terminal_clock_o = ~tx_terminal_clock_o;
   end
   // data moves on the falling edge, so it is steady at the rise
   always @(negedge tx_terminal_clock_o[0]) seq <= seq + 2'h1;
   assign tx_pos_data_o = {NCH{seq == 2'h3}};
   assign tx_neg_data_o = {NCH{seq == 2'h1}};
endmodule

/* cll_top_tb.sv */
`timescale 1ns/1ps
module cll_top_tb;
   logic clk, rst, host, shut, wr_s;
   logic [3:0] lsel, rsel, aone, rlp, mp, mn, txp, txn, txc, rxp, rxc, tlp, tln, oe, fault;
   logic [3:0] rxn, rln;
   logic [4:0] addr, wdata, rdata;
   int mismatches = 0;
   int n_tests = 0;
   int nc, nr, nt, nn;
   cll_framer_model cll_framer_model_inst (.tx_pos_data_o(txp), .tx_neg_data_o(txn),
      .tx_terminal_clock_o(txc));
   cll_top #(.DM_PERIODS(8)) cll_top_inst (.ref_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
      .host_mode_i(host), .transmitter_shutoff_i(shut), .local_loop_select_i(lsel),
      .remote_loop_select_i(rsel), .send_all_ones_i(aone), .reg_addr_i(addr),
      .reg_wr_i(wr_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .tx_pos_data_i(txp),
      .tx_neg_data_i(txn), .tx_terminal_clock_i(txc), .rx_pos_data_o(rxp),
      .rx_neg_data_o(rxn), .rx_recovered_clock_o(rxc), .rx_line_pos_i(rlp),
      .rx_line_neg_i(rln), .rx_line_clock_i(4'h0), .tx_line_pos_o(tlp),
      .tx_line_neg_o(tln), .tx_line_oe_o(oe), .monitor_pos_input_i(mp),
      .monitor_neg_input_i(mn), .drive_fault_flag_o(fault));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // the strobe drops a full cycle before any next request
   task automatic wr(input logic [4:0] a, input logic [4:0] d);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      tick(1);
      wr_s = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [4:0] a, input logic [4:0] e, input string what);
      addr = a;
      tick(1);
      chk(what, {3'h0, e}, {3'h0, rdata});
   endtask
   // receive line held at a mark; counts clock rises, receive marks, line marks
   task automatic probe();
      logic pc;
      nc = 0;
      nr = 0;
      nt = 0;
      nn = 0;
      pc = rxc[0];
      rlp[0] = 1'b1;
      rln[0] = 1'b1;
      repeat (40) begin
         tick(1);
         if (rxc[0] === 1'b1 && pc === 1'b0) nc++;
         if (rxp[0] === 1'b1) nr++;
         if (rxn[0] === 1'b1) nn++;
         if (tlp[0] === 1'b1 || tln[0] === 1'b1) nt++;
         pc = rxc[0];
      end
      rlp[0] = 1'b0;
      rln[0] = 1'b0;
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #200000;
      mismatches++;
      finish_test();
   end
   initial begin
      rst = 1'b1;
      {host, shut, wr_s, lsel, rsel, aone, rlp, rln, mp, mn, addr, wdata} = 41'h0;
      tick(10);
      rst = 1'b0;
      tick(2);
      for (int k = 0; k < 4; k++) begin
         rd(5'(8 * k), 5'h00, "status reset");
         rd(5'(8 * k + 1), 5'h00, "txctl reset");
         rd(5'(8 * k + 4), 5'h00, "loop reset");
      end
      wr(5'h08, 5'h1F);
      rd(5'h08, 5'h00, "status read only");
      wr(5'h09, 5'h1F);
      rd(5'h09, 5'h1E, "txctl mask");
      wr(5'h0C, 5'h1F);
      rd(5'h0C, 5'h0F, "loop mask");
      wr(5'h05, 5'h1F);
      rd(5'h05, 5'h00, "unmapped");
      wr(5'h09, 5'h00);
      wr(5'h0C, 5'h00);
      $display("test registers done");
      // hardware pins first, then the loop register of channel 0
      for (int m = 0; m < 8; m++) begin
         host = m[2];
         if (m[2]) wr(5'h04, {3'h0, m[1:0]});
         else {lsel[0], rsel[0]} = m[1:0];
         tick(40);
         probe();
         chk("rx follows line", {7'h00, !m[1]}, {7'h00, nr >= 30});
         chk("rx neg follows line", {7'h00, !m[1]}, {7'h00, nn >= 30});
         chk("line echoes rx", {7'h00, m[1:0] == 2'h1}, {7'h00, nt >= 30});
         chk("rx clock from tx", {7'h00, m[1]}, {7'h00, nc >= 3});
      end
      wr(5'h04, 5'h00);
      {lsel[0], rsel[0]} = 2'h0;
      $display("test loopback done");
      for (int k = 0; k < 4; k++) begin
         host = !k[1];
         if (k[1]) aone[0] = !k[0];
         else wr(5'h01, k[0] ? 5'h00 : 5'h08);
         tick(40);
         probe();
         chk("all ones", {7'h00, !k[0]}, {7'h00, nt >= 38});
      end
      $display("test all ones done");
      host = 1'b1;
      tick(8);
      chk("drivers on", 8'h0F, {4'h0, oe});
      wr(5'h11, 5'h10);
      tick(4);
      chk("channel 2 off", 8'h0B, {4'h0, oe});
      shut = 1'b1;
      tick(6);
      chk("global off", 8'h00, {4'h0, oe});
      shut = 1'b0;
      wr(5'h11, 5'h00);
      tick(6);
      chk("all released", 8'h0F, {4'h0, oe});
      $display("test shutoff done");
      repeat (6) begin
         mp[0] = !mp[0];
         tick(32);
         chk("fault low", 8'h00, {7'h00, fault[0]});
      end
      tick(120);
      chk("fault set", 8'h01, {7'h00, fault[0]});
      rd(5'h00, 5'h01, "status fault");
      mn[0] = 1'b1;
      tick(10);
      chk("neg monitor clears", 8'h00, {7'h00, fault[0]});
      $display("test drive monitor done");
      finish_test();
   end
endmodule
